/* gpwm_pkg.sv */
// Constants shared by the 24-channel grayscale PWM sink driver.
// Assumes a 40 MHz system clock; the 4 MHz PWM rate is derived from it.
package gpwm_pkg;
   // Channel layout
   localparam int CH_NUM        = 24;
   localparam int GS_W          = 12;
   localparam int SHREG_W       = CH_NUM * GS_W;
   localparam int GROUP_SIZE    = 4;
   // Rates in Hz
   localparam int SYS_CLK_HZ    = 32'h0262_5A00;
   localparam int OSC_HZ        = 32'h003D_0900;
   localparam int OSC_DIV       = SYS_CLK_HZ / OSC_HZ;
   localparam int DIV_W         = $clog2(OSC_DIV);
   // Turn-on delay per group, in oscillator cycles
   localparam int GROUP_DELAY   = 2;
   // Reset values and counter maximum
   localparam logic [GS_W-1:0]  GS_CNT_RST = 12'h000;
   localparam logic [GS_W-1:0]  GS_CNT_MAX = 12'hFFF;
   localparam logic [DIV_W-1:0] DIV_RST    = 4'h0;
endpackage : gpwm_pkg

/* gpwm_driver.sv */
// Grayscale PWM sink driver: serial shift chain, display latch, PWM engine.
// Assumes all pin inputs are asynchronous to sys_clk and that shift_clock
// phases last well over two sys_clk periods.
`timescale 1ns/100ps

// Function
// - Blank high forces every sink output off.
// - Blank high clears the grayscale counter and timing control.
// - Blank low lets outputs follow PWM from latched values.
// - Shift clock rising edge loads serial input into shift register LSB.
// - Shift clock rising edge moves shift register one bit toward MSB.
// - Serial output stage takes MSB on shift clock falling edge.
// - Latch strobe rising edge copies shift register into display latch.
// - After latch strobe, outputs stay off until next display period.
// - Latch strobe does not clear the grayscale counter.
// - Twenty-four channels, each with a twelve-bit grayscale value.
// - Display periods repeat continuously using latest latched values.
// - Grayscale counter runs on internal 4 MHz rate, not shift clock.
// - Overtemperature turns all outputs off; they resume when it clears.
// - Outputs turn on in groups of four with delay between groups.
module gpwm_driver
   import gpwm_pkg::*;
#(
   parameter int NUM_CH = CH_NUM,
   parameter int GRP_DLY = GROUP_DELAY
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              shift_clock,
   input  wire logic              serial_in,
   input  wire logic              latch_strobe,
   input  wire logic              output_blank,
   input  wire logic              overtemp_cutoff,
   output logic                   serial_out,
   output logic [NUM_CH-1:0]      sink_outputs
);

   localparam int SR_W = NUM_CH * GS_W;

   // Synchronisers: stage 1 feeds stage 2 only
   logic [4:0]            sync1_q;
   logic [4:0]            sync2_q;
   logic                  sclk_prev_q;
   logic                  latch_strobe_prev_q;
   logic                  sclk_s;
   logic                  sin_s;
   logic                  latch_strobe_s;
   logic                  blank_s;
   logic                  ot_s;
   logic                  sclk_rise;
   logic                  sclk_fall;
   logic                  latch_strobe_rise;

   // Shift chain and display
   logic [SR_W-1:0]       shreg_q;
   logic [SR_W-1:0]       shreg_d;
   logic [SR_W-1:0]       latch_q;
   logic                  serial_out_q;
   logic                  hold_q;
   logic                  hold_d;

   // PWM timing
   logic [DIV_W-1:0]      div_q;
   logic [DIV_W-1:0]      div_d;
   logic                  osc_en_q;
   logic                  div_wrap;
   logic [GS_W-1:0]       gs_cnt_q;
   logic [GS_W-1:0]       gs_cnt_d;
   logic                  cnt_wrap;
   logic [NUM_CH-1:0]     pwm_on;
   logic [NUM_CH-1:0]     sink_d;
   logic [NUM_CH-1:0]     sink_q;
   logic                  force_off;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         sclk_prev_q <= 1'b0;
         latch_strobe_prev_q <= 1'b0;
      end else begin
         sync1_q <= {overtemp_cutoff, output_blank, latch_strobe,
                     serial_in, shift_clock};
         sync2_q <= sync1_q;
         sclk_prev_q <= sclk_s;
         latch_strobe_prev_q <= latch_strobe_s;
      end
   end

   assign sclk_s    = sync2_q[0];
   assign sin_s     = sync2_q[1];
   assign latch_strobe_s    = sync2_q[2];
   assign blank_s   = sync2_q[3];
   assign ot_s      = sync2_q[4];
   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign sclk_fall = ~sclk_s & sclk_prev_q;
   assign latch_strobe_rise = latch_strobe_s & ~latch_strobe_prev_q;

   // Data and clock pass equal sync delay, so the bit stays aligned
   assign shreg_d = sclk_rise ? {shreg_q[SR_W-2:0], sin_s} : shreg_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shreg_q <= '0;
         serial_out_q  <= 1'b0;
      end else begin
         shreg_q <= shreg_d;
         if (sclk_fall) begin
            serial_out_q <= shreg_q[SR_W-1];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         latch_q <= '0;
      end else if (latch_strobe_rise) begin
         latch_q <= shreg_q;
      end
   end

   // Internal oscillator as an enable pulse, free of shift_clock
   assign div_wrap = (div_q == DIV_W'(OSC_DIV - 1));
   assign div_d    = div_wrap ? DIV_RST : div_q + 1'b1;

   // Counter wraps after maximum; blank holds it and the divider at zero
   assign cnt_wrap = osc_en_q & (gs_cnt_q == GS_CNT_MAX);
   assign gs_cnt_d = blank_s  ? GS_CNT_RST :
                     osc_en_q ? gs_cnt_q + 1'b1 : gs_cnt_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_q    <= DIV_RST;
         osc_en_q <= 1'b0;
         gs_cnt_q <= GS_CNT_RST;
      end else begin
         div_q    <= blank_s ? DIV_RST : div_d;
         osc_en_q <= div_wrap & ~blank_s;
         gs_cnt_q <= gs_cnt_d;
      end
   end

   // Set by the latch wins over the period-start clear
   assign hold_d = latch_strobe_rise ? 1'b1 :
                   (cnt_wrap | blank_s) ? 1'b0 : hold_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
      end
   end

   // Later groups lose the tail of long values; the period is not stretched
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      localparam logic [GS_W:0] OFF = (GS_W+1)'((c / GROUP_SIZE) * GRP_DLY);
      wire [GS_W:0] cnt_x = {1'b0, gs_cnt_q};
      wire [GS_W:0] gs_x  = {1'b0, latch_q[c*GS_W +: GS_W]};
      assign pwm_on[c] = (cnt_x >= OFF) && (cnt_x < OFF + gs_x);
   end

   assign force_off = blank_s | hold_q | ot_s;
   assign sink_d    = force_off ? '0 : pwm_on;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sink_q <= '0;
      end else begin
         sink_q <= sink_d;
      end
   end

   assign sink_outputs = sink_q;
   assign serial_out   = serial_out_q;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_latch_ev;
      latch_strobe_rise ##1 hold_q;
   endsequence

   property p_blank_off;
      blank_s |=> (sink_q == '0);
   endproperty
   a_blank_off: assert property (p_blank_off)
      else $error("outputs on during blank");

   property p_blank_clr;
      blank_s |=> (gs_cnt_q == GS_CNT_RST) && !osc_en_q;
   endproperty
   a_blank_clr: assert property (p_blank_clr)
      else $error("counter not cleared by blank");

   property p_pwm_ch0;
      !blank_s && !hold_q && !ot_s && (gs_cnt_q < latch_q[GS_W-1:0])
         |=> sink_q[0];
   endproperty
   a_pwm_ch0: assert property (p_pwm_ch0)
      else $error("channel zero off inside its on time");

   property p_shift_in;
      sclk_rise |=> shreg_q[0] == $past(sin_s);
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("serial bit not captured");

   property p_shift_move;
      sclk_rise |=> shreg_q[SR_W-1:1] == $past(shreg_q[SR_W-2:0]);
   endproperty
   a_shift_move: assert property (p_shift_move)
      else $error("shift by other than one bit");

   property p_serial_out;
      sclk_fall |=> serial_out == $past(shreg_q[SR_W-1]);
   endproperty
   a_serial_out: assert property (p_serial_out)
      else $error("serial out not updated on falling edge");

   property p_latch;
      latch_strobe_rise |=> latch_q == $past(shreg_q);
   endproperty
   a_latch: assert property (p_latch)
      else $error("latch copy wrong");

   property p_latch_off;
      s_latch_ev |=> (sink_q == '0);
   endproperty
   a_latch_off: assert property (p_latch_off)
      else $error("outputs on after latch before period start");

   property p_no_clr;
      latch_strobe_rise && !blank_s && !osc_en_q |=> gs_cnt_q == $past(gs_cnt_q);
   endproperty
   a_no_clr: assert property (p_no_clr)
      else $error("latch disturbed the counter");

   property p_wrap;
      cnt_wrap && !blank_s && !latch_strobe_rise
         |=> (gs_cnt_q == GS_CNT_RST) && !hold_q;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("period did not restart");

   property p_osc;
      osc_en_q |=> !osc_en_q [*8];
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator enable too frequent");

   property p_ot;
      ot_s |=> (sink_q == '0);
   endproperty
   a_ot: assert property (p_ot)
      else $error("outputs on during overtemperature");

   property p_group;
      (gs_cnt_q < GS_W'(GRP_DLY)) |=> (sink_q[NUM_CH-1:GROUP_SIZE] == '0);
   endproperty
   a_group: assert property (p_group)
      else $error("later group on before its delay");

   property p_blank_div;
      blank_s |=> (div_q == DIV_RST);
   endproperty
   a_blank_div: assert property (p_blank_div)
      else $error("timing divider not cleared by blank");

   property p_cnt_step;
      osc_en_q && !blank_s |=> gs_cnt_q == $past(gs_cnt_q) + GS_W'(1);
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("counter did not advance on oscillator tick");

   property p_cnt_hold;
      !osc_en_q && !blank_s |=> $stable(gs_cnt_q);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold)
      else $error("counter moved without oscillator tick");

   property p_latch_keep;
      !latch_strobe_rise |=> $stable(latch_q);
   endproperty
   a_latch_keep: assert property (p_latch_keep)
      else $error("display latch changed without strobe");

   property p_shift_hold;
      !sclk_rise |=> $stable(shreg_q);
   endproperty
   a_shift_hold: assert property (p_shift_hold)
      else $error("shift register moved without shift clock");

   property p_serial_out_hold;
      !sclk_fall |=> $stable(serial_out);
   endproperty
   a_serial_out_hold: assert property (p_serial_out_hold)
      else $error("serial out changed off the falling edge");

   property p_group_last;
      (gs_cnt_q < GS_W'((NUM_CH / GROUP_SIZE - 1) * GRP_DLY))
         |=> (sink_q[NUM_CH-1 -: GROUP_SIZE] == '0);
   endproperty
   a_group_last: assert property (p_group_last)
      else $error("last group on before its delay");

endmodule // gpwm_driver

/* gpwm_host.sv */
// Host model: shifts grayscale frames and pulses the latch strobe.
// Assumes sys_clk is the bench clock; the link clock idles low between frames.
`timescale 1ns/100ps
module gpwm_host
   import gpwm_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic serial_out,
   output logic      shift_clock,
   output logic      serial_in,
   output logic      latch_strobe
);
   initial begin
      shift_clock = 1'b0;
      serial_in = 1'b0;
      latch_strobe = 1'b0;
   end
   // Data moves on the falling link edge, far from the sampling rise
   task automatic send(input logic [SHREG_W-1:0] d,
                       output logic [SHREG_W-1:0] got);
      @(posedge sys_clk) #1;
      for (int i = SHREG_W - 1; i >= 0; i--) begin
         shift_clock = 1'b0;
         serial_in = d[i];
         #100 shift_clock = 1'b1;
         #100 got[i] = serial_out;
      end
      shift_clock = 1'b0;
      #100 serial_in = ~d[0];
   endtask
   task automatic latch();
      @(posedge sys_clk) #1;
      latch_strobe = 1'b1;
      #200 latch_strobe = 1'b0;
   endtask
endmodule // gpwm_host

/* tb_top.sv */
// Self-checking bench for the grayscale PWM sink driver.
// Assumes counts are reckoned from the release of blank, ten clocks each.
`timescale 1ns/100ps
module tb_top
   import gpwm_pkg::*;
;
   logic               sys_clk;
   logic               rst;
   logic               output_blank;
   logic               overtemp_cutoff;
   logic               shift_clock;
   logic               serial_in;
   logic               latch_strobe;
   logic               serial_out;
   logic [CH_NUM-1:0]  sink_outputs;
   logic [SHREG_W-1:0] fa;
   logic [SHREG_W-1:0] fb;
   logic [SHREG_W-1:0] got;
   int                 errors = 0;
   int                 num_checks = 0;
   int                 cyc = 0;
   int                 rel = 0;

   gpwm_driver #(.NUM_CH(CH_NUM), .GRP_DLY(GROUP_DELAY)) uut (.sys_clk,
      .rst, .shift_clock, .serial_in, .latch_strobe, .output_blank,
      .overtemp_cutoff, .serial_out, .sink_outputs);
   gpwm_host host (.sys_clk, .serial_out, .shift_clock, .serial_in,
      .latch_strobe);

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Whole run is near 72000 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [SHREG_W-1:0] a, e);
      num_checks++;
      if (a !== e) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, a, e);
      end
   endtask
   function automatic logic [CH_NUM-1:0] pat(input logic [SHREG_W-1:0] d,
                                             input int k);
      int off;
      for (int c = 0; c < CH_NUM; c++) begin
         off = (c / GROUP_SIZE) * GROUP_DELAY;
         pat[c] = k >= off && k < off + int'(d[c*GS_W +: GS_W]);
      end
   endfunction
   // Sample mid-count so sync latency cannot blur the boundary
   task automatic at(input int k);
      while (cyc < rel + OSC_DIV * k + 8) @(posedge sys_clk);
      #1;
   endtask
   task automatic t_serial();
      host.send(fa, got);
      chk(got, '0);
      host.send(fb, got);
      chk(got, fa);
      host.latch();
      repeat (8) @(posedge sys_clk);
      #1 chk(sink_outputs, '0);
   endtask
   task automatic t_pwm();
      int ks[7] = '{1, 5, 9, 11, 170, 1000, 2040};
      output_blank = 1'b0;
      rel = cyc;
      foreach (ks[i]) begin
         at(ks[i]);
         chk(sink_outputs, pat(fb, ks[i]));
      end
   endtask
   task automatic t_faults();
      at(2500);
      overtemp_cutoff = 1'b1;
      at(2501);
      chk(sink_outputs, '0);
      overtemp_cutoff = 1'b0;
      at(2503);
      chk(sink_outputs, pat(fb, 2503));
      output_blank = 1'b1;
      at(2601);
      chk(sink_outputs, '0);
      output_blank = 1'b0;
      rel = cyc;
      at(3);
      chk(sink_outputs, pat(fb, 3));
   endtask
   task automatic t_relatch();
      host.send(fa, got);
      chk(got, fb);
      at(4060);
      host.latch();
      at(4070);
      chk(sink_outputs, '0);
      at(4101);
      chk(sink_outputs, pat(fa, 5));
      at(4130);
      chk(sink_outputs, pat(fa, 34));
   endtask

   initial begin
      rst = 1'b1;
      output_blank = 1'b1;
      overtemp_cutoff = 1'b0;
      for (int c = 0; c < CH_NUM; c++) begin
         fb[c*GS_W +: GS_W] = (c == 0) ? 12'h000 :
            (c == CH_NUM - 1) ? 12'hFFF : GS_W'(c * 170);
      end
      fa = ~fb;
      repeat (3) @(posedge sys_clk);
      #1 rst = 1'b0;
      chk({serial_out, sink_outputs}, '0);
      t_serial();
      t_pwm();
      t_faults();
      t_relatch();
      stop_test();
   end
endmodule // tb_top
